// [pkg/acr_pkg.sv]
// Shared constants for the converter control block
package acr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register bus geometry
	localparam int          ADDR_W   = 8;      // Byte address width
	localparam int          DATA_W   = 32;     // Wishbone data width
	localparam logic [7:0]  CTRL_OFS = 8'h00;  // converter_control
	localparam logic [7:0]  STAT_OFS = 8'h04;  // Interrupt status, write one to clear
	localparam logic [7:0]  MASK_OFS = 8'h08;  // Interrupt mask

	////////////////////////////////////////////////////////////////////////
	// converter_control field layout
	localparam int          EN_BIT   = 0;      // converter_enable
	localparam int          GO_BIT   = 1;      // Start / in progress
	localparam int          SEL_LSB  = 2;      // channel_select low bit
	localparam int          SEL_MSB  = 5;      // channel_select high bit
	localparam int          CTRL_W   = 8;      // Register width
	localparam logic [1:0]  CTRL_TOP = 2'h0;   // Bits 7..6 read value
	localparam logic [3:0]  SEL_RST  = 4'h0;   // Channel after reset
	localparam logic        EN_RST   = 1'b0;   // Enable after reset

	////////////////////////////////////////////////////////////////////////
	// Channel codes
	localparam int          NUM_AN   = 14;     // Analog inputs 0..13
	localparam logic [3:0]  SEL_LAST = 4'hd;   // Highest analog input code
	localparam logic [3:0]  SEL_RSVD = 4'he;   // Reserved code
	localparam logic [3:0]  SEL_REF  = 4'hf;   // fixed_voltage_reference

	////////////////////////////////////////////////////////////////////////
	// Interrupt layout
	localparam int          IRQ_W    = 2;      // Number of events
	localparam int          DONE_IRQ = 0;      // Conversion finished
	localparam int          RFSD_IRQ = 1;      // Start refused
	localparam logic [1:0]  IRQ_RST  = 2'h0;   // Status and mask reset

	// Sequencer states, Gray coded along idle-start-busy-done
	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_START = 2'b01,
		SEQ_BUSY  = 2'b11,
		SEQ_DONE  = 2'b10
	} acr_seq_state_t;

endpackage

// [pkg/acr_seq_if.sv]
// Link between the register front end and the conversion sequencer
interface acr_seq_if;
	logic startReq;   // One-cycle request to begin a conversion
	logic abort;      // Level, converter switched off
	logic coreDone;   // One-cycle completion from the analog core
	logic busy;       // Level, conversion running
	logic donePulse;  // One-cycle, conversion finished normally
	logic coreStart;  // One-cycle start strobe to the analog core

	// Register front end
	modport ctl (
		output startReq, abort, coreDone,
		input  busy, donePulse, coreStart
	);

	// Sequencer
	modport seq (
		input  startReq, abort, coreDone,
		output busy, donePulse, coreStart
	);
endinterface

// [hw/acr_conv_seq.sv]
// Conversion sequencer: issues the start strobe and waits for the core
module acr_conv_seq
	import acr_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Front end link
	acr_seq_if.seq   sif
);

	acr_seq_state_t state_r;      // Current step
	logic           busy_r;       // Running flag
	logic           donePulse_r;  // Completion strobe
	logic           coreStart_r;  // Start strobe to the core

	////////////////////////////////////////////////////////////////////////
	// State and strobes; abort beats everything so a powered-down core
	// never leaves the start bit stuck high
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_r     <= SEQ_IDLE;
			busy_r      <= 1'b0;
			donePulse_r <= 1'b0;
			coreStart_r <= 1'b0;
		end else begin
			donePulse_r <= 1'b0;
			coreStart_r <= 1'b0;
			case (state_r)
				// Waiting; the done step also accepts a new start
				SEQ_IDLE, SEQ_DONE: begin
					state_r <= SEQ_IDLE;
					if (sif.startReq && !sif.abort) begin
						state_r     <= SEQ_START;  // RULE3
						busy_r      <= 1'b1;
						coreStart_r <= 1'b1;
					end
				end
				// Strobe issued, now wait for the core
				SEQ_START: begin
					state_r <= sif.abort ? SEQ_IDLE : SEQ_BUSY;
					busy_r  <= !sif.abort;
				end
				// Conversion running
				SEQ_BUSY: begin
					if (sif.abort) begin
						state_r <= SEQ_IDLE;
						busy_r  <= 1'b0;
					end else if (sif.coreDone) begin
						state_r     <= SEQ_DONE;  // RULE4
						busy_r      <= 1'b0;
						donePulse_r <= 1'b1;
					end
				end
				default: begin
					state_r <= SEQ_IDLE;
					busy_r  <= 1'b0;
				end
			endcase
		end
	end

	assign sif.busy      = busy_r;
	assign sif.donePulse = donePulse_r;
	assign sif.coreStart = coreStart_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	strobeOne_a: assert property (coreStart_r |=> !coreStart_r && busy_r) // RULE3
		else $error("start strobe not a single cycle");
	doneDrop_a: assert property (donePulse_r |-> !busy_r ##1 !donePulse_r) // RULE4
		else $error("busy still set after completion");
	abortIdle_a: assert property (sif.abort && busy_r |=> !busy_r) // RULE6
		else $error("conversion survived converter disable");

endmodule

// [hw/acr_ctl_top.sv]
// Notes on behaviour
// RULE1: Bits 5..2 pick analog inputs 0..13.
// RULE2: Code 1110 reserved; 1111 routes fixed reference.
// RULE3: Writing one to bit 1 starts conversion.
// RULE4: Hardware clears start bit when conversion ends.
// RULE5: Start bit reads one only while converting.
// RULE6: Bit 0 enables converter; zero powers down.
// RULE7: Bits 7..6 ignore writes, read zero.
// RULE8: Reset clears every control bit.
module acr_ctl_top
	import acr_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              nrst,
	// Wishbone slave
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [DATA_W-1:0] dat_i,
	output logic      [DATA_W-1:0] dat_o,
	output logic                   ack_o,
	// Interrupt
	output logic                   irq,
	// Analog core
	output logic                   coreEnable,
	output logic      [NUM_AN-1:0] chanSel,
	output logic                   fvrSel,
	output logic                   coreStart,
	input  wire logic              coreDone
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	acr_seq_if              sif ();          // Sequencer link
	logic                   ack_r;           // Bus acknowledge
	logic [DATA_W-1:0]      datO_r;          // Read data
	logic                   enable_r;        // converter_enable
	logic [3:0]             chanSel_r;       // channel_select
	logic                   startReq_r;      // Start accepted, one cycle
	logic [IRQ_W-1:0]       stat_r;          // Sticky events
	logic [IRQ_W-1:0]       mask_r;          // Event mask
	logic                   irq_r;           // Interrupt line
	logic                   coreEnable_r;    // Core power
	logic [NUM_AN-1:0]      chanOut_r;       // One-hot input mux
	logic                   fvrOut_r;        // Reference routing
	logic                   goBit;           // Start bit as read
	logic                   busReq;          // New bus request this cycle
	logic                   wrCtrl;          // Control byte write
	logic                   wrStat;          // Status write
	logic                   wrMask;          // Mask write
	logic                   enable_nxt;      // Enable after this write
	logic [3:0]             chanSel_nxt;     // Channel after this write
	logic                   goWr;            // Write asks for a start
	logic                   startOk;         // Start may go ahead
	logic [IRQ_W-1:0]       statSet;         // Events this cycle
	logic [IRQ_W-1:0]       statClr;         // Software clears
	logic [CTRL_W-1:0]      ctrlByte;        // Control register image
	logic [DATA_W-1:0]      rdData_nxt;      // Read mux result
	logic                   firstCyc_r;      // Helper, first cycle out of reset

	////////////////////////////////////////////////////////////////////////
	// Bus decode; a request is served once, in the cycle before ack
	assign busReq = cyc_i && stb_i && !ack_r;
	always_comb begin
		wrCtrl = 1'b0;
		wrStat = 1'b0;
		wrMask = 1'b0;
		if (busReq && we_i && sel_i[0]) begin
			if (adr_i == CTRL_OFS) begin
				wrCtrl = 1'b1;
			end else if (adr_i == STAT_OFS) begin
				wrStat = 1'b1;
			end else if (adr_i == MASK_OFS) begin
				wrMask = 1'b1;
			end
		end
	end

	// Values the write would leave behind
	assign enable_nxt  = wrCtrl ? dat_i[EN_BIT] : enable_r;
	assign chanSel_nxt = wrCtrl ? dat_i[SEL_MSB:SEL_LSB] : chanSel_r;
	assign goWr        = wrCtrl && dat_i[GO_BIT] && !goBit;
	// A start needs the converter on and a routable channel
	assign startOk = enable_nxt && (chanSel_nxt != SEL_RSVD); // RULE2

	// Start bit reads the running state, not a stored software value
	assign goBit = startReq_r || sif.busy; // RULE5

	////////////////////////////////////////////////////////////////////////
	// Acknowledge: one wait state, dropped the cycle after it is given
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= busReq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses answer with zero
	assign ctrlByte = {CTRL_TOP, chanSel_r, goBit, enable_r}; // RULE7
	always_comb begin
		rdData_nxt = '0;
		if (adr_i == CTRL_OFS) begin
			rdData_nxt[CTRL_W-1:0] = ctrlByte;
		end else if (adr_i == STAT_OFS) begin
			rdData_nxt[IRQ_W-1:0] = stat_r;
		end else if (adr_i == MASK_OFS) begin
			rdData_nxt[IRQ_W-1:0] = mask_r;
		end
	end

	// Read data captured with the acknowledge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			datO_r <= '0;
		end else if (busReq && !we_i) begin
			datO_r <= rdData_nxt; // RULE5
		end else begin
			datO_r <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control fields; bits 7..6 have no storage so writes vanish
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			enable_r  <= EN_RST;  // RULE8
			chanSel_r <= SEL_RST; // RULE8
		end else if (wrCtrl) begin
			enable_r  <= dat_i[EN_BIT];          // RULE6
			chanSel_r <= dat_i[SEL_MSB:SEL_LSB]; // RULE1
		end
	end

	// Start request; a one written while running is simply ignored
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			startReq_r <= 1'b0;
		end else begin
			startReq_r <= goWr && startOk; // RULE3
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer hookup
	assign sif.startReq = startReq_r;
	assign sif.abort    = !enable_r; // RULE6
	assign sif.coreDone = coreDone;

	acr_conv_seq uSeq (
		.mclk (mclk),
		.nrst (nrst),
		.sif  (sif)
	);

	////////////////////////////////////////////////////////////////////////
	// Analog core outputs, registered; everything parked when disabled
	// so the mux and reference draw nothing
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			coreEnable_r <= 1'b0;
			chanOut_r    <= '0;
			fvrOut_r     <= 1'b0;
		end else begin
			coreEnable_r <= enable_r; // RULE6
			chanOut_r    <= '0;
			fvrOut_r     <= 1'b0;
			if (enable_r && chanSel_r <= SEL_LAST) begin
				chanOut_r <= NUM_AN'(1) << chanSel_r; // RULE1
			end else if (enable_r && chanSel_r == SEL_REF) begin
				fvrOut_r <= 1'b1; // RULE2
			end
		end
	end

	assign coreEnable = coreEnable_r;
	assign chanSel    = chanOut_r;
	assign fvrSel     = fvrOut_r;
	assign coreStart  = sif.coreStart;

	////////////////////////////////////////////////////////////////////////
	// Interrupt status: set beats a simultaneous write-one clear
	always_comb begin
		statSet           = '0;
		statSet[DONE_IRQ] = sif.donePulse;
		statSet[RFSD_IRQ] = goWr && !startOk;
	end
	assign statClr = wrStat ? dat_i[IRQ_W-1:0] : '0;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stat_r <= IRQ_RST;
		end else begin
			stat_r <= (stat_r & ~statClr) | statSet;
		end
	end

	// Mask register, same layout as status
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mask_r <= IRQ_RST;
		end else if (wrMask) begin
			mask_r <= dat_i[IRQ_W-1:0];
		end
	end

	// Level interrupt, one cycle behind the status
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(stat_r & mask_r);
		end
	end

	assign ack_o = ack_r;
	assign dat_o = datO_r;
	assign irq   = irq_r;

	////////////////////////////////////////////////////////////////////////
	// Helper for the reset check; only the assertions read it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			firstCyc_r <= 1'b1;
		end else begin
			firstCyc_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	chanOneHot_a: assert property ( // RULE1
		enable_r && chanSel_r <= SEL_LAST |=> chanSel == (NUM_AN'(1) << $past(chanSel_r)))
		else $error("analog input mux does not match channel");

	fvrRoute_a: assert property ( // RULE2
		enable_r && chanSel_r == SEL_REF |=> fvrSel && chanSel == '0)
		else $error("reference not routed for code 1111");

	reservedNone_a: assert property ( // RULE2
		chanSel_r == SEL_RSVD |=> !fvrSel && chanSel == '0)
		else $error("reserved code routed something");

	startBegin_a: assert property ( // RULE3
		wrCtrl && dat_i[GO_BIT] && !goBit && startOk |=> ##1 coreStart)
		else $error("start write did not reach the core");

	goClears_a: assert property ( // RULE4
		sif.donePulse |-> !goBit)
		else $error("start bit still set after completion");

	goReads_a: assert property ( // RULE5
		busReq && !we_i && adr_i == CTRL_OFS |=> ack_o && dat_o[GO_BIT] == $past(goBit))
		else $error("start bit readback wrong");

	enableOff_a: assert property ( // RULE6
		!enable_r [*2] |-> !coreEnable && chanSel == '0 && !fvrSel && !coreStart)
		else $error("core active while disabled");

	upperZero_a: assert property ( // RULE7
		ack_o |-> dat_o[CTRL_W-1:SEL_MSB+1] == CTRL_TOP)
		else $error("unimplemented bits read nonzero");

	resetZero_a: assert property ( // RULE8
		firstCyc_r |-> ctrlByte == '0)
		else $error("control bits not clear after reset");

	irqLevel_a: assert property (
		|(stat_r & mask_r) |=> irq)
		else $error("interrupt missing for unmasked event");

	convDone_c: cover property (coreStart ##[1:50] sif.donePulse);
	startRefused_c: cover property (goWr && !startOk);
	abortRun_c: cover property (sif.busy && !enable_r);
	irqRaised_c: cover property ($rose(irq));

endmodule

// [tb/tb_adc_control_register.sv]
module tb_adc_control_register
	import acr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////
	// Design ports and bench state
	logic              mclk = 1'b0;   // 40 MHz system clock
	logic              nrst = 1'b0;   // Async reset, active low
	logic              cyc = 1'b0;    // Wishbone cycle
	logic              stb = 1'b0;    // Wishbone strobe
	logic              we = 1'b0;     // Write direction
	logic [ADDR_W-1:0] adr = 8'h00;   // Byte address
	logic [3:0]        sel = 4'h0;    // Byte selects
	logic [DATA_W-1:0] dat = 32'h0;   // Write data
	logic [DATA_W-1:0] datO;          // Read data
	logic              ack;           // Acknowledge
	logic              irq;           // Level interrupt
	logic              coreEn;        // Converter power
	logic [NUM_AN-1:0] chanSel;       // One-hot input select
	logic              fvrSel;        // Fixed reference routed
	logic              coreStart;     // Start strobe to the core
	logic              coreDone = 1'b0; // Completion from the core
	logic [32:0]       expQ[$];       // Notes: {check, expected read data}
	logic [32:0]       note;          // Oldest note taken by the monitor
	int                n_errors = 0;  // Mismatches seen
	int                checked = 0;   // Comparisons made
	int                nStarts = 0;   // Start strobes seen at the core side
	integer            seed = 14;     // Fixed seed keeps runs repeatable
	logic [31:0]       rnd;           // Random filler for ignored bits
	logic [3:0]        code;          // Channel code under test

	// Half period of 12.5 ns gives 25 ns
	always #12.5 mclk = ~mclk;

	acr_ctl_top dut_u (
		.mclk(mclk), .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(dat), .dat_o(datO), .ack_o(ack), .irq(irq),
		.coreEnable(coreEn), .chanSel(chanSel), .fvrSel(fvrSel),
		.coreStart(coreStart), .coreDone(coreDone)
	);

	////////////////////////////////////////////////////////////////////////
	// Reporting
	task automatic wrap_up;
		if (n_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// One comparison, reported at once on a mismatch
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Wishbone master: one classic cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic c, input logic [31:0] e);
		int k;
		k = 0;
		@(posedge mclk);
		expQ.push_back({c, e});
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		// Bounded wait: a slave that never answers ends the run
		do begin
			@(posedge mclk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (ack !== 1'b1) begin
			chk("ack timeout", 32'h1, {31'h0, ack});
			wrap_up();
		end else begin
			cyc <= 1'b0;
			stb <= 1'b0;
			we  <= 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf, 1'b0, 32'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hf, 1'b1, e);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Monitor: each acknowledge consumes the oldest note
	always @(posedge mclk) begin
		if (ack === 1'b1) begin
			if (expQ.size() == 0) begin
				chk("unexpected ack", 32'h0, 32'h1);
			end else begin
				note = expQ.pop_front();
				if (note[32]) begin
					chk("read data", note[31:0], datO);
				end
			end
		end
	end

	// Count start strobes so a lost or extra conversion shows up
	always @(posedge mclk) begin
		if (coreStart === 1'b1) begin
			nStarts++;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		idle(8);
		nrst <= 1'b1;
		idle(1);
		// Everything starts cleared
		rd(CTRL_OFS, 32'h0);
		rd(STAT_OFS, 32'h0);
		rd(MASK_OFS, 32'h0);
		chk("enable", 32'h0, {31'h0, coreEn});
		// Sweep every channel code; top bits and upper lanes get random junk
		for (int i = 0; i < 16; i++) begin
			code = i[3:0];
			rnd = $random(seed);
			wr(CTRL_OFS, {rnd[31:6], code, 2'b01});
			rd(CTRL_OFS, {26'h0, code, 2'b01});
			chk("chanSel", {18'h0, (code < 4'he) ? (14'h0001 << code) : 14'h0}, {18'h0, chanSel});
			chk("fvrSel", {31'h0, code == 4'hf}, {31'h0, fvrSel});
		end
		// Lane 0 not selected: write must not land
		bus(1'b1, CTRL_OFS, 32'h0, 4'he, 1'b0, 32'h0);
		rd(CTRL_OFS, 32'h3d);
		// Unmapped address reads zero and swallows writes
		wr(8'h0c, 32'hff);
		rd(8'h0c, 32'h0);
		rd(CTRL_OFS, 32'h3d);
		// Normal conversion on input 3, with a restart attempt while busy
		wr(MASK_OFS, 32'h3);
		wr(CTRL_OFS, 32'h0f);
		idle(4);
		chk("starts", 32'h1, nStarts);
		rd(CTRL_OFS, 32'h0f);
		wr(CTRL_OFS, 32'h0f);
		idle(4);
		chk("restart ignored", 32'h1, nStarts);
		@(posedge mclk);
		coreDone <= 1'b1;
		@(posedge mclk);
		coreDone <= 1'b0;
		idle(3);
		chk("irq done", 32'h1, {31'h0, irq});
		rd(CTRL_OFS, 32'h0d);
		rd(STAT_OFS, 32'h1);
		wr(STAT_OFS, 32'h1);
		idle(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		// Reserved code refuses a start
		wr(CTRL_OFS, 32'h3b);
		idle(4);
		chk("reserved start", 32'h1, nStarts);
		rd(STAT_OFS, 32'h2);
		rd(CTRL_OFS, 32'h39);
		wr(STAT_OFS, 32'h2);
		// Start with the converter off is refused too
		wr(CTRL_OFS, 32'h06);
		idle(4);
		chk("off start", 32'h1, nStarts);
		chk("enable off", 32'h0, {31'h0, coreEn});
		rd(STAT_OFS, 32'h2);
		wr(STAT_OFS, 32'h2);
		// Switching off mid-conversion aborts without a done event
		wr(CTRL_OFS, 32'h07);
		idle(4);
		chk("enable on", 32'h1, {31'h0, coreEn});
		wr(CTRL_OFS, 32'h04);
		idle(3);
		rd(CTRL_OFS, 32'h04);
		rd(STAT_OFS, 32'h0);
		// Let the monitor take the last note before the totals are read
		idle(2);
		chk("enable dropped", 32'h0, {31'h0, coreEn});
		chk("starts total", 32'h2, nStarts);
		chk("notes left", 32'h0, expQ.size());
		wrap_up();
	end
endmodule
